// file: design/free_running_timer_compare.sv
/*
 16-bit free-running timer with one output compare register, reached over a
 plain register port (address, strobes, read data one cycle later).
 Assumes the CPU core applies its own interrupt mask to timer_irq and that
 halt_mode and por_start come from the same clock domain.
*/
// Decided for this implementation: strobed register access.
// Function
// - Count advances once per tick; tick is the clock divided by four.
// - Count readable anytime without change via primary and alternate pairs.
// - High byte read returns high byte and latches live low byte.
// - Latched low byte holds over repeat high reads; low read returns it.
// - Without a started sequence, low byte read returns live low byte.
// - Reset loads FFFCh; after power-on, counting waits for oscillator startup.
// - Overflow flag sets when count wraps FFFFh to 0000h.
// - Overflow flag requests interrupt only when enabled and CPU unmasked.
// - Overflow clears after status read with flag set, then primary low access.
// - Alternate pair reads never touch the overflow clearing sequence.
// - Each increment is triggered on a CPU clock edge.
// - Count runs in wait, freezes in halt, resumes from the frozen count.
// - Compare register fully read/write, untouched by hardware and reset.
// - Compare happens once per tick at first phase; flag sets on equality.
// - Compare flag requests interrupt only when enabled and CPU unmasked.
// - Compare flag clears after status read then compare low byte access.
// - Compare high write inhibits compares until the low byte is written.
// - Control bit 6 compare enable, bit 5 overflow enable; others zero.
// - Status is read-only: compare flag bit 6, overflow flag bit 5.
`timescale 1ns/1ps
`default_nettype none
`include "frt_consts.svh"
module free_running_timer_compare
	import frt_pkg::*;
#(
	parameter int STARTUP_CYCLES = `STARTUP_CYCLES
) (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       por_start,
	input  wire logic       halt_mode,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            timer_irq
);
	// ==========================================================
	// Declarations
	logic [15:0] count;
	logic [15:0] compare_value;
	logic [7:0]  low_hold;
	logic        hold_valid;
	logic        compare_inhibit;
	logic        compare_irq_enable;
	logic        overflow_irq_enable;
	logic        compare_match_flag;
	logic        overflow_flag;
	logic        ovf_armed;
	logic        cmp_armed;
	logic        starting;
	logic [12:0] start_count;
	logic        tick;
	logic        compare_slot;
	logic        run;
	logic        rd_pri_low;
	logic        rd_alt_low;
	logic        any_count_high_rd;
	logic        any_count_low_rd;
	logic        acc_pri_low;
	logic        acc_cmp_low;
	logic        status_rd;
	logic        wrap_event;
	logic        match_event;
	logic [7:0]  next_rdata;

	localparam logic [12:0] START_LAST = 13'(STARTUP_CYCLES - 1);
	localparam logic [7:0]  CTRL_INIT  = `CTRL_RESET;

	// ==========================================================
	// Address decode
	assign rd_pri_low  = reg_rd && (reg_addr == `OFS_COUNT_PRI_LOW);
	assign rd_alt_low  = reg_rd && (reg_addr == `OFS_COUNT_ALT_LOW);
	assign any_count_high_rd = reg_rd && ((reg_addr == `OFS_COUNT_PRI_HIGH) ||
		(reg_addr == `OFS_COUNT_ALT_HIGH));
	assign any_count_low_rd = rd_pri_low || rd_alt_low;
	// Primary low counts as an access on read or write; alternate never does
	assign acc_pri_low = (reg_rd || reg_wr) && (reg_addr == `OFS_COUNT_PRI_LOW);
	assign acc_cmp_low = (reg_rd || reg_wr) && (reg_addr == `OFS_COMPARE_LOW);
	assign status_rd   = reg_rd && (reg_addr == `OFS_FLAG_STATUS);

	// ==========================================================
	// Oscillator startup hold after a power-on reset
	// por_start pulses once after a power-on reset; plain resets skip the wait
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			starting    <= 1'b0;
			start_count <= 13'h0000;
		end else if (por_start) begin
			starting    <= 1'b1;
			start_count <= 13'h0000;
		end else if (starting) begin
			if (start_count == START_LAST) begin
				starting <= 1'b0;
			end
			start_count <= start_count + 13'h0001;
		end
	end

	// Halt freezes counter and prescaler; wait mode is invisible here
	assign run = !halt_mode && !starting && !por_start;

	tick_prescaler u_prescaler (
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.run          (run),
		.tick         (tick),
		.compare_slot (compare_slot)
	);

	// ==========================================================
	// Free-running counter
	// Single rising-edge domain stands in for the falling CPU edge; only
	// the phase relation to bus accesses differs, not the count rate
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= `COUNT_RESET;
		end else if (tick) begin
			count <= count + 16'h0001;
		end
	end

	assign wrap_event  = tick && (count == 16'hffff);
	assign match_event = compare_slot && !compare_inhibit &&
		(compare_value == count);

	// ==========================================================
	// Read latch for the count low byte
	// Latch on the first high read of a sequence; a low read ends the sequence
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_valid <= 1'b0;
			low_hold   <= 8'h00;
		end else if (any_count_high_rd) begin
			if (!hold_valid) begin
				low_hold <= count[7:0];
			end
			hold_valid <= 1'b1;
		end else if (any_count_low_rd) begin
			hold_valid <= 1'b0;
		end
	end

	// ==========================================================
	// Control register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			compare_irq_enable  <= CTRL_INIT[`BIT_COMPARE];
			overflow_irq_enable <= CTRL_INIT[`BIT_OVERFLOW];
		end else if (reg_wr && reg_addr == `OFS_IRQ_ENABLE_CTRL) begin
			compare_irq_enable  <= reg_wdata[`BIT_COMPARE];
			overflow_irq_enable <= reg_wdata[`BIT_OVERFLOW];
		end
	end

	// ==========================================================
	// Compare register: no reset, plain storage when unused
	always_ff @(posedge ref_clk) begin
		if (reg_wr && reg_addr == `OFS_COMPARE_HIGH) begin
			compare_value[15:8] <= reg_wdata;
		end
		if (reg_wr && reg_addr == `OFS_COMPARE_LOW) begin
			compare_value[7:0] <= reg_wdata;
		end
	end

	// High write suspends compares until the low byte lands
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			compare_inhibit <= 1'b0;
		end else if (reg_wr && reg_addr == `OFS_COMPARE_HIGH) begin
			compare_inhibit <= 1'b1;
		end else if (reg_wr && reg_addr == `OFS_COMPARE_LOW) begin
			compare_inhibit <= 1'b0;
		end
	end

	// ==========================================================
	// Overflow flag with two-step clear; a new wrap beats the clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			overflow_flag <= 1'b0;
			ovf_armed     <= 1'b0;
		end else begin
			if (wrap_event) begin
				overflow_flag <= 1'b1;
			end else if (ovf_armed && acc_pri_low) begin
				overflow_flag <= 1'b0;
			end
			if (status_rd && overflow_flag) begin
				ovf_armed <= 1'b1;
			end else if (acc_pri_low || wrap_event) begin
				ovf_armed <= 1'b0;
			end
		end
	end

	// Compare flag with two-step clear; a new match beats the clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			compare_match_flag <= 1'b0;
			cmp_armed          <= 1'b0;
		end else begin
			if (match_event) begin
				compare_match_flag <= 1'b1;
			end else if (cmp_armed && acc_cmp_low) begin
				compare_match_flag <= 1'b0;
			end
			if (status_rd && compare_match_flag) begin
				cmp_armed <= 1'b1;
			end else if (acc_cmp_low || match_event) begin
				cmp_armed <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Interrupt request; the core applies its own mask, so a masked
	// request simply stays pending in the flag
	assign timer_irq = (compare_match_flag && compare_irq_enable) ||
		(overflow_flag && overflow_irq_enable);

	// ==========================================================
	// Read mux; registered so data stand one cycle after the strobe
	always_comb begin
		next_rdata = 8'h00;
		unique case (reg_addr)
			`OFS_IRQ_ENABLE_CTRL: begin
				next_rdata[`BIT_COMPARE]  = compare_irq_enable;
				next_rdata[`BIT_OVERFLOW] = overflow_irq_enable;
			end
			`OFS_FLAG_STATUS: begin
				next_rdata[`BIT_COMPARE]  = compare_match_flag;
				next_rdata[`BIT_OVERFLOW] = overflow_flag;
			end
			`OFS_COMPARE_HIGH: next_rdata = compare_value[15:8];
			`OFS_COMPARE_LOW:  next_rdata = compare_value[7:0];
			`OFS_COUNT_PRI_HIGH, `OFS_COUNT_ALT_HIGH: next_rdata = count[15:8];
			`OFS_COUNT_PRI_LOW, `OFS_COUNT_ALT_LOW: begin
				next_rdata = hold_valid ? low_hold : count[7:0];
			end
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ==========================================================
	// Checks
	a_count_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
		tick |=> count == $past(count) + 16'h0001)
		else $error("count did not step on tick");
	a_count_still: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!tick |=> count == $past(count))
		else $error("count moved without tick");
	a_halt_freeze: assert property (@(posedge ref_clk) disable iff (!rst_n)
		halt_mode [*2] |-> $stable(count))
		else $error("count moved in halt");
	a_wrap_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wrap_event |=> overflow_flag)
		else $error("overflow flag missed the wrap");
	a_alt_keeps_ovf: assert property (@(posedge ref_clk) disable iff (!rst_n)
		overflow_flag && !acc_pri_low |=> overflow_flag)
		else $error("overflow flag cleared without primary access");
	a_cmp_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$fell(compare_match_flag) |-> $past(cmp_armed && acc_cmp_low))
		else $error("compare flag cleared without sequence");
	a_inhibit_cmp: assert property (@(posedge ref_clk) disable iff (!rst_n)
		compare_inhibit |=> !$rose(compare_match_flag))
		else $error("compare fired while inhibited");
	a_low_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		hold_valid && any_count_low_rd |=> reg_rdata == $past(low_hold))
		else $error("low read did not return latched byte");
	a_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
		timer_irq |-> (overflow_flag && overflow_irq_enable) ||
			(compare_match_flag && compare_irq_enable))
		else $error("interrupt without enabled flag");
	a_start_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
		por_start |=> !tick [*8])
		else $error("counting before startup delay");

	// Flags move only through their own event or their clear sequence
	a_wrap_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(overflow_flag) |-> $past(wrap_event))
		else $error("overflow flag rose without a wrap");
	a_ovf_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$fell(overflow_flag) |-> $past(ovf_armed && acc_pri_low))
		else $error("overflow flag cleared without sequence");
	a_match_slot: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(compare_match_flag) |-> $past(compare_slot))
		else $error("compare flag rose outside the compare slot");
	a_inhibit_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && reg_addr == `OFS_COMPARE_HIGH |=> compare_inhibit)
		else $error("high compare write left compares enabled");

	// Readback layout and the low byte latch; software relies on both
	a_ctrl_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		reg_rd && reg_addr == `OFS_IRQ_ENABLE_CTRL |=> reg_rdata ==
			{1'b0, $past(compare_irq_enable), $past(overflow_irq_enable), 5'h00})
		else $error("control readback layout wrong");
	a_status_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		reg_rd && reg_addr == `OFS_FLAG_STATUS |=> reg_rdata ==
			{1'b0, $past(compare_match_flag), $past(overflow_flag), 5'h00})
		else $error("status readback layout wrong");
	a_latch_take: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!hold_valid && any_count_high_rd |=> low_hold == $past(count[7:0]))
		else $error("high read did not latch the low byte");
	a_latch_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
		hold_valid && any_count_high_rd |=> low_hold == $past(low_hold))
		else $error("repeat high read moved the latch");
	a_live_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!hold_valid && any_count_low_rd |=> reg_rdata == $past(count[7:0]))
		else $error("plain low read did not return live byte");
	a_cmp_store: assert property (@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && reg_addr == `OFS_COMPARE_LOW |=>
			compare_value[7:0] == $past(reg_wdata))
		else $error("compare low byte did not store the write");

	c_wrap:   cover property (@(posedge ref_clk) disable iff (!rst_n) wrap_event);
	c_match:  cover property (@(posedge ref_clk) disable iff (!rst_n) match_event);
	c_irq:    cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(timer_irq));
	c_clear:  cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(overflow_flag));
	c_seqrd:  cover property (@(posedge ref_clk) disable iff (!rst_n)
		any_count_high_rd ##1 any_count_low_rd);
endmodule
`default_nettype wire

// file: design/frt_consts.svh
/*
 Constants for the free-running timer with output compare: register offsets,
 field positions, reset values and timing counts. Assumes one 10 MHz clock.
*/
`ifndef FRT_CONSTS_SVH
`define FRT_CONSTS_SVH

// ==========================================================
// Register offsets (byte addresses on the plain port)
`define OFS_IRQ_ENABLE_CTRL  8'h12
`define OFS_FLAG_STATUS      8'h13
`define OFS_COMPARE_HIGH     8'h16
`define OFS_COMPARE_LOW      8'h17
`define OFS_COUNT_PRI_HIGH   8'h18
`define OFS_COUNT_PRI_LOW    8'h19
`define OFS_COUNT_ALT_HIGH   8'h1a
`define OFS_COUNT_ALT_LOW    8'h1b

// ==========================================================
// Field positions
`define BIT_COMPARE  6
`define BIT_OVERFLOW 5

// ==========================================================
// Reset values and timing
`define COUNT_RESET      16'hfffc
`define CTRL_RESET       8'h00
`define PRESCALE_DIV     4
`define STARTUP_CYCLES   4096

`endif

// file: design/frt_pkg.sv
/*
 Types shared by the timer files. Assumes frt_consts.svh beside it.
*/
`default_nettype none
package frt_pkg;
	// Prescaler phase, one-hot; first phase is the compare slot
	typedef enum logic [3:0] {
		PH_T0 = 4'b0001,
		PH_T1 = 4'b0010,
		PH_T2 = 4'b0100,
		PH_T3 = 4'b1000
	} phase_t;
endpackage
`default_nettype wire

// file: design/tick_prescaler.sv
/*
 Fixed divide-by-four prescaler. Produces one tick per four clocks and a
 phase marker for the compare slot. Assumes halt and startup hold it still.
*/
`timescale 1ns/1ps
`default_nettype none
module tick_prescaler
	import frt_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic run,
	output logic      tick,
	output logic      compare_slot
);
	// ==========================================================
	// Phase rotation
	phase_t phase;

	// Rotate only while running, so a halt freezes the phase too
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= PH_T0;
		end else if (run) begin
			unique case (phase)
				PH_T0: phase <= PH_T1;
				PH_T1: phase <= PH_T2;
				PH_T2: phase <= PH_T3;
				PH_T3: phase <= PH_T0;
				default: phase <= PH_T0;
			endcase
		end
	end

	// Tick at the last phase, compare at the first
	assign tick         = run && (phase == PH_T3);
	assign compare_slot = run && (phase == PH_T0);

	a_tick_spacing: assert property (@(posedge ref_clk) disable iff (!rst_n)
		tick |=> !tick [*3])
		else $error("tick came sooner than four cycles");
endmodule
`default_nettype wire

// file: testbench/cpu_irq_gate.sv
/*
 Model of the host core's interrupt mask in front of the timer request.
 Assumes the timer request is a level that stays up while a flag is pending.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_irq_gate (
	input  wire logic timer_irq,
	input  wire logic cpu_mask,
	output logic      cpu_irq
);
	// ==========================================================
	// Masking
	// Core sees the request only while unmasked; the flag itself stays pending
	assign cpu_irq = timer_irq & ~cpu_mask;
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
/*
 Self-checking bench for the free-running timer: register port tasks and
 directed sequences. Assumes one 10 MHz clock and a short startup count.
*/
`timescale 1ns/1ps
`default_nettype none
`include "frt_consts.svh"
module tb_top;
	import frt_pkg::*;
	localparam int STARTUP = 16;
	logic        ref_clk;
	logic        rst_n;
	logic        por_start;
	logic        halt_mode;
	logic        reg_wr;
	logic        reg_rd;
	logic        cpu_mask;
	logic        timer_irq;
	logic        cpu_irq;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic [7:0]  d;
	logic [7:0]  lo;
	logic [15:0] tgt;
	int          bad_count = 0;
	int          cmp_count = 0;

	// ==========================================================
	// Instances
	free_running_timer_compare #(.STARTUP_CYCLES(STARTUP)) i_free_running_timer_compare (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.por_start (por_start),
		.halt_mode (halt_mode),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_rdata (reg_rdata),
		.timer_irq (timer_irq)
	);
	cpu_irq_gate i_cpu_irq_gate (
		.timer_irq (timer_irq),
		.cpu_mask  (cpu_mask),
		.cpu_irq   (cpu_irq)
	);

	// ==========================================================
	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// ==========================================================
	// Port tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// Data stands only in the cycle after the read edge
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
		logic [7:0] v;
		rd(a, v);
		chk(n, e, v);
	endtask
	task automatic ck_irq(input logic e, input logic ec);
		#1;
		chk("timer_irq", {7'h00, e}, {7'h00, timer_irq});
		chk("cpu_irq", {7'h00, ec}, {7'h00, cpu_irq});
	endtask
	// Reset held two cycles; power-on adds the startup pulse
	task automatic do_rst(input logic por);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		cyc(2);
		rst_n     <= 1'b1;
		por_start <= por;
		@(posedge ref_clk);
		por_start <= 1'b0;
	endtask
	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		$display("Error watchdog expired");
		stop_test();
	end

	// ==========================================================
	// Tests; early steps must land before the first wrap at 16 edges
	initial begin
		rst_n     = 1'b0;
		por_start = 1'b0;
		halt_mode = 1'b0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		cpu_mask  = 1'b0;
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		do_rst(1'b0);
		wr(8'h16, 8'ha5);
		wr(8'h17, 8'h3c);
		rc(8'h13, 8'h00, "status");
		rc(8'h12, `CTRL_RESET, "ctrl");
		rc(8'h1a, 8'(`COUNT_RESET >> 8), "count hi");
		// Low access without an armed status read keeps the flag
		cyc(12);
		rd(8'h19, d);
		rc(8'h13, 8'h20, "overflow");
		rd(8'h1b, d);
		rc(8'h13, 8'h20, "alt keeps");
		// Pending request follows its enable and the core mask
		wr(8'h12, 8'h20);
		ck_irq(1'b1, 1'b1);
		cpu_mask <= 1'b1;
		ck_irq(1'b1, 1'b0);
		cpu_mask <= 1'b0;
		wr(8'h12, 8'h00);
		ck_irq(1'b0, 1'b0);
		wr(8'h12, 8'hff);
		rc(8'h12, 8'h60, "ctrl bits");
		wr(8'h12, 8'h20);
		ck_irq(1'b1, 1'b1);
		wr(8'h19, 8'h00);
		rc(8'h13, 8'h00, "tof clear");
		ck_irq(1'b0, 1'b0);
		wr(8'h13, 8'hff);
		rc(8'h13, 8'h00, "status ro");
		rc(8'h20, 8'h00, "unmapped");
		rc(8'h16, 8'ha5, "cmp hi");
		rc(8'h17, 8'h3c, "cmp lo");
		// Reads four edges apart see exactly one tick
		rd(8'h1b, lo);
		cyc(2);
		rc(8'h1b, lo + 8'h01, "live lo");
		// Forty halted edges add nothing; nine running edges add two
		rd(8'h1b, lo);
		@(posedge ref_clk);
		halt_mode <= 1'b1;
		cyc(40);
		halt_mode <= 1'b0;
		cyc(6);
		rc(8'h1b, lo + 8'h02, "halt");
		// Repeat high reads keep the first latched low byte
		rd(8'h1b, lo);
		cyc(2);
		rd(8'h18, d);
		cyc(20);
		rd(8'h18, d);
		cyc(5);
		rc(8'h19, lo + 8'h01, "latched lo");
		// High write without a low write keeps compares off
		rd(8'h1a, d);
		rd(8'h1b, lo);
		tgt = {d, lo} + 16'h0010;
		cpu_mask <= 1'b1;
		wr(8'h17, tgt[7:0]);
		wr(8'h16, tgt[15:8]);
		cpu_mask <= 1'b0;
		cyc(100);
		rc(8'h13, 8'h00, "inhibit");
		// Safe update order, then a match some sixteen ticks ahead
		rd(8'h1a, d);
		rd(8'h1b, lo);
		tgt = {d, lo} + 16'h0010;
		cpu_mask <= 1'b1;
		wr(8'h16, tgt[15:8]);
		rd(8'h13, d);
		wr(8'h17, tgt[7:0]);
		cpu_mask <= 1'b0;
		cyc(100);
		rc(8'h13, 8'h40, "match");
		wr(8'h12, 8'h40);
		ck_irq(1'b1, 1'b1);
		cpu_mask <= 1'b1;
		ck_irq(1'b1, 1'b0);
		cpu_mask <= 1'b0;
		rd(8'h13, d);
		rd(8'h17, d);
		rc(8'h13, 8'h00, "ocf clear");
		ck_irq(1'b0, 1'b0);
		// Lone low write keeps compares live; high byte already equals the count's
		rd(8'h1b, lo);
		tgt = {tgt[15:8], lo + 8'h10};
		wr(8'h17, tgt[7:0]);
		cyc(100);
		rc(8'h13, 8'h40, "low only");
		ck_irq(1'b1, 1'b1);
		// Power-on reset holds the count through the startup wait
		do_rst(1'b1);
		rc(8'h1b, 8'hfc, "por hold");
		cyc(6);
		rc(8'h1b, 8'hfc, "por hold");
		rc(8'h16, tgt[15:8], "cmp hi kept");
		rc(8'h17, tgt[7:0], "cmp lo kept");
		rc(8'h12, 8'h00, "ctrl reset");
		cyc(20);
		rd(8'h1b, lo);
		cyc(2);
		rc(8'h1b, lo + 8'h01, "por runs");
		stop_test();
	end
endmodule
`default_nettype wire
